// ---- rtl/sss_sequencer.sv ----
`timescale 1ns/1ps
module sss_sequencer (
  input logic CLK_IN,
  input logic NRST_IN,
  input logic CE_IN,
  input sss_pkg::sss_bus_s REG_BUS_IN,
  input logic [7:0] WAKE_SRC_IN,
  output logic [31:0] RDATA_OUT,
  output logic PROC_HALT_CLK_N_OUT,
  output sss_pkg::sss_ctl_s SEQ_CTL_OUT,
  output logic CPU_RESET_OUT,
  output logic DEV_RESET_OUT,
  output logic FW_REQ_OUT,
  output logic IRQ_OUT
);
  localparam int EXIT_MAX = 5 * sss_pkg::STEP_CYC + 10;

  typedef struct packed {
    sss_pkg::sss_state_e fsm;
    logic [2:0] typ;
    logic cs_mode;
    logic [2:0] act_typ;
    logic act_cs;
    logic [2:0] step;
    sss_pkg::sss_ctl_s ctl;
    logic halt_n;
    logic cpu_rst;
    logic dev_rst;
    logic wake_flag;
    logic [7:0] wake_en;
    logic [2:0] int_sts;
    logic [2:0] int_en;
    logic irq;
    logic fw_req;
    logic [31:0] rdata;
  } sss_main_s;
  sss_main_s st;
  sss_main_s next_st;
  logic tmr_start;
  logic tmr_done;
  logic wake;
  logic [7:0] wake_hit;
  logic [2:0] ev;
  logic [2:0] nsteps;
  logic [2:0] step_up;
  logic [2:0] step_dn;

  // ----------------------------------------------------------------
  // Sequence tables
  // ----------------------------------------------------------------
  // Controls asserted once n steps of the entry for type t are done
  function automatic sss_pkg::sss_ctl_s seq_ctl(input logic [2:0] t, input logic cs,
                                                input logic [2:0] n);
    sss_pkg::sss_ctl_s c;
    c = '0;
    if (t == sss_pkg::TYP_S1) begin
      // Power and memory stay up: all context but caches survives
      c.halt = (n >= 3'h1);
      c.clk_stop = cs && (n >= 3'h2);
      c.self_ref = cs && (n >= 3'h3);
      c.pll_stby = cs && (n >= 3'h4);
    end else if (t == sss_pkg::TYP_S2) begin
      c.halt = (n >= 3'h1);
      c.clk_stop = (n >= 3'h1);
      c.pll_stby = (n >= 3'h1);
      c.self_ref = (n >= 3'h2);
      c.cpu_off = (n >= 3'h3);
    end else if (t == sss_pkg::TYP_S3) begin
      c.self_ref = (n >= 3'h1);
      c.mem_iso = (n >= 3'h2);
      c.halt = (n >= 3'h3);
      c.clk_stop = (n >= 3'h3);
      c.pll_stby = (n >= 3'h3);
      c.cpu_off = (n >= 3'h3);
      c.pwr_off = (n >= 3'h3);
    end else if (t == sss_pkg::TYP_S4) begin
      c.halt = (n >= 3'h1);
      c.clk_stop = (n >= 3'h1);
      c.pll_stby = (n >= 3'h1);
      c.cpu_off = (n >= 3'h1);
      c.pwr_off = (n >= 3'h1);
    end
    return c;
  endfunction

  // Zero steps marks an unsupported sleep type code
  function automatic logic [2:0] seq_len(input logic [2:0] t, input logic cs);
    logic [2:0] l;
    l = 3'h0;
    if (t == sss_pkg::TYP_S1) begin
      l = cs ? 3'h4 : 3'h1;
    end else if (t == sss_pkg::TYP_S2 || t == sss_pkg::TYP_S3) begin
      l = 3'h3;
    end else if (t == sss_pkg::TYP_S4) begin
      l = 3'h1;
    end
    return l;
  endfunction

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  sss_step_timer u_tmr (
    .clk_in(CLK_IN),
    .nrst_in(NRST_IN),
    .ce_in(CE_IN),
    .start_in(tmr_start),
    .done_out(tmr_done)
  );

  sss_wake_qual u_wake (
    .clk_in(CLK_IN),
    .nrst_in(NRST_IN),
    .ce_in(CE_IN),
    .src_in(WAKE_SRC_IN),
    .en_in(st.wake_en),
    .hit_out(wake_hit),
    .wake_out(wake)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.fw_req = 1'b0;
    next_st.rdata = 32'h0000_0000;
    tmr_start = 1'b0;
    ev = 3'h0;
    nsteps = seq_len(st.act_typ, st.act_cs);
    step_up = 3'(st.step + 3'h1);
    step_dn = 3'(st.step - 3'h1);
    // Register writes
    if (REG_BUS_IN.wr) begin
      if (REG_BUS_IN.addr == sss_pkg::A_CTRL) begin
        // Type field frozen outside idle so firmware can read it after wake
        if (st.fsm == sss_pkg::ST_IDLE) begin
          next_st.typ = REG_BUS_IN.wdata[sss_pkg::CTRL_TYP_LSB +: 3];
          next_st.cs_mode = REG_BUS_IN.wdata[sss_pkg::CTRL_CS_BIT];
        end
      end else if (REG_BUS_IN.addr == sss_pkg::A_STATUS) begin
        if (REG_BUS_IN.wdata[sss_pkg::STAT_WAKE_BIT]) begin
          next_st.wake_flag = 1'b0;
        end
      end else if (REG_BUS_IN.addr == sss_pkg::A_WAKE_EN) begin
        next_st.wake_en = REG_BUS_IN.wdata[7:0];
      end else if (REG_BUS_IN.addr == sss_pkg::A_INT_EN) begin
        next_st.int_en = REG_BUS_IN.wdata[2:0];
      end else if (REG_BUS_IN.addr == sss_pkg::A_INT_CLR) begin
        next_st.int_sts = st.int_sts & ~REG_BUS_IN.wdata[2:0];
      end else if (REG_BUS_IN.addr == sss_pkg::A_FW_CMD) begin
        if (REG_BUS_IN.wdata[7:0] == sss_pkg::FW_HIB_REQ) begin
          next_st.fw_req = 1'b1;
          ev[sss_pkg::INT_FW] = 1'b1;
        end
      end
    end
    // Register reads, data shown in the following cycle only
    if (REG_BUS_IN.rd) begin
      if (REG_BUS_IN.addr == sss_pkg::A_CTRL) begin
        next_st.rdata[sss_pkg::CTRL_TYP_LSB +: 3] = st.typ;
        next_st.rdata[sss_pkg::CTRL_CS_BIT] = st.cs_mode;
      end else if (REG_BUS_IN.addr == sss_pkg::A_STATUS) begin
        next_st.rdata[sss_pkg::STAT_WAKE_BIT] = st.wake_flag;
        next_st.rdata[sss_pkg::STAT_FSM_LSB +: 4] = st.fsm;
        next_st.rdata[sss_pkg::STAT_STEP_LSB +: 3] = st.step;
        next_st.rdata[sss_pkg::STAT_CPURST_BIT] = st.cpu_rst;
        next_st.rdata[sss_pkg::STAT_DEVRST_BIT] = st.dev_rst;
        next_st.rdata[sss_pkg::STAT_SRC_LSB +: 8] = wake_hit;
      end else if (REG_BUS_IN.addr == sss_pkg::A_WAKE_EN) begin
        next_st.rdata[7:0] = st.wake_en;
      end else if (REG_BUS_IN.addr == sss_pkg::A_INT_STS) begin
        next_st.rdata[2:0] = st.int_sts;
      end else if (REG_BUS_IN.addr == sss_pkg::A_INT_EN) begin
        next_st.rdata[2:0] = st.int_en;
      end
    end
    // Sequencer
    case (st.fsm)
      sss_pkg::ST_IDLE: begin
        // Go bit is consumed here and never stored
        if (REG_BUS_IN.wr && REG_BUS_IN.addr == sss_pkg::A_CTRL &&
            REG_BUS_IN.wdata[sss_pkg::CTRL_GO_BIT] &&
            seq_len(REG_BUS_IN.wdata[sss_pkg::CTRL_TYP_LSB +: 3],
                    REG_BUS_IN.wdata[sss_pkg::CTRL_CS_BIT]) != 3'h0) begin
          next_st.act_typ = REG_BUS_IN.wdata[sss_pkg::CTRL_TYP_LSB +: 3];
          next_st.act_cs = REG_BUS_IN.wdata[sss_pkg::CTRL_CS_BIT];
          next_st.step = 3'h0;
          next_st.fsm = sss_pkg::ST_ENTER;
          tmr_start = 1'b1;
        end
      end
      sss_pkg::ST_ENTER: begin
        if (tmr_done) begin
          next_st.step = step_up;
          next_st.ctl = seq_ctl(st.act_typ, st.act_cs, step_up);
          if (step_up == nsteps) begin
            next_st.fsm = sss_pkg::ST_SLEEP;
            ev[sss_pkg::INT_SLEEP] = 1'b1;
          end else begin
            tmr_start = 1'b1;
          end
        end
      end
      sss_pkg::ST_SLEEP: begin
        if (wake) begin
          next_st.fsm = sss_pkg::ST_EXIT;
          tmr_start = 1'b1;
          next_st.cpu_rst = (st.act_typ != sss_pkg::TYP_S1);
          next_st.dev_rst = (st.act_typ == sss_pkg::TYP_S3) ||
                            (st.act_typ == sss_pkg::TYP_S4);
        end
      end
      sss_pkg::ST_EXIT: begin
        // Steps undone last-first: clocks return no later than the step that lifts halt
        if (tmr_done) begin
          next_st.step = step_dn;
          next_st.ctl = seq_ctl(st.act_typ, st.act_cs, step_dn);
          if (step_dn == 3'h0) begin
            next_st.fsm = sss_pkg::ST_IDLE;
            next_st.cpu_rst = 1'b0;
            next_st.dev_rst = 1'b0;
            ev[sss_pkg::INT_WAKE] = 1'b1;
          end else begin
            tmr_start = 1'b1;
          end
        end
      end
      default: begin
        next_st.fsm = sss_pkg::ST_IDLE;
      end
    endcase
    // Hardware set wins over a software clear in the same cycle
    if (next_st.fsm == sss_pkg::ST_SLEEP) begin
      next_st.wake_flag = 1'b1;
    end
    next_st.int_sts = next_st.int_sts | ev;
    next_st.irq = |(next_st.int_sts & next_st.int_en);
    next_st.halt_n = ~next_st.ctl.halt;
  end

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      st <= '0;
      st.fsm <= sss_pkg::ST_IDLE;
      st.halt_n <= 1'b1;
      st.wake_en <= sss_pkg::RST_WAKE_EN;
      st.int_en <= sss_pkg::RST_INT_EN;
    end else if (CE_IN) begin
      st <= next_st;
    end
  end

  assign RDATA_OUT = st.rdata;
  assign PROC_HALT_CLK_N_OUT = st.halt_n;
  assign SEQ_CTL_OUT = st.ctl;
  assign CPU_RESET_OUT = st.cpu_rst;
  assign DEV_RESET_OUT = st.dev_rst;
  assign FW_REQ_OUT = st.fw_req;
  assign IRQ_OUT = st.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_s1_halt;
    @(posedge CLK_IN) disable iff (!NRST_IN || !CE_IN)
    st.fsm == sss_pkg::ST_SLEEP && st.act_typ == sss_pkg::TYP_S1 |-> !PROC_HALT_CLK_N_OUT;
  endproperty
  a_s1_halt: assert property (p_s1_halt) else $error("halt clock not asserted");

  property p_sg_release;
    @(posedge CLK_IN) disable iff (!NRST_IN || !CE_IN)
    st.fsm == sss_pkg::ST_SLEEP && st.act_typ == sss_pkg::TYP_S1 && !st.act_cs && wake
    |-> ##[1:EXIT_MAX] PROC_HALT_CLK_N_OUT;
  endproperty
  a_sg_release: assert property (p_sg_release) else $error("halt clock not released");

  property p_cs_order;
    @(posedge CLK_IN) disable iff (!NRST_IN || !CE_IN)
    $rose(st.ctl.pll_stby) && st.act_typ == sss_pkg::TYP_S1
    |-> st.ctl.halt && st.ctl.clk_stop && st.ctl.self_ref && $past(st.ctl.self_ref);
  endproperty
  a_cs_order: assert property (p_cs_order) else $error("clock stop order wrong");

  property p_clk_first;
    @(posedge CLK_IN) disable iff (!NRST_IN || !CE_IN)
    $fell(st.ctl.halt) |-> !st.ctl.pll_stby && !st.ctl.clk_stop && !st.ctl.pwr_off;
  endproperty
  a_clk_first: assert property (p_clk_first) else $error("processor resumed first");

  property p_s2_order;
    @(posedge CLK_IN) disable iff (!NRST_IN || !CE_IN)
    $rose(st.ctl.cpu_off) && st.act_typ == sss_pkg::TYP_S2
    |-> st.ctl.self_ref && st.ctl.pll_stby && !st.ctl.pwr_off;
  endproperty
  a_s2_order: assert property (p_s2_order) else $error("second state order wrong");

  property p_s2_reset;
    @(posedge CLK_IN) disable iff (!NRST_IN || !CE_IN)
    st.fsm == sss_pkg::ST_EXIT && st.act_typ == sss_pkg::TYP_S2 |-> st.cpu_rst && !st.dev_rst;
  endproperty
  a_s2_reset: assert property (p_s2_reset) else $error("second state reset wrong");

  property p_s3_order;
    @(posedge CLK_IN) disable iff (!NRST_IN || !CE_IN)
    $rose(st.ctl.pwr_off) && st.act_typ == sss_pkg::TYP_S3
    |-> st.ctl.mem_iso && $past(st.ctl.mem_iso) && st.ctl.self_ref;
  endproperty
  a_s3_order: assert property (p_s3_order) else $error("third state order wrong");

  property p_s3_reset;
    @(posedge CLK_IN) disable iff (!NRST_IN || !CE_IN)
    st.fsm == sss_pkg::ST_EXIT && st.act_typ == sss_pkg::TYP_S3 |-> st.cpu_rst && st.dev_rst;
  endproperty
  a_s3_reset: assert property (p_s3_reset) else $error("third state reset missing");

  property p_s4_off;
    @(posedge CLK_IN) disable iff (!NRST_IN || !CE_IN)
    st.fsm == sss_pkg::ST_SLEEP && st.act_typ == sss_pkg::TYP_S4
    |-> st.ctl.pwr_off && st.ctl.cpu_off;
  endproperty
  a_s4_off: assert property (p_s4_off) else $error("deepest state not off");

  property p_fw_req;
    @(posedge CLK_IN) disable iff (!NRST_IN || !CE_IN)
    REG_BUS_IN.wr && REG_BUS_IN.addr == sss_pkg::A_FW_CMD &&
    REG_BUS_IN.wdata[7:0] == sss_pkg::FW_HIB_REQ |=> FW_REQ_OUT ##1
    (!FW_REQ_OUT || $past(REG_BUS_IN.wr && REG_BUS_IN.wdata[7:0] == sss_pkg::FW_HIB_REQ));
  endproperty
  a_fw_req: assert property (p_fw_req) else $error("firmware request not passed");

  property p_wake_flag;
    @(posedge CLK_IN) disable iff (!NRST_IN || !CE_IN)
    st.fsm == sss_pkg::ST_SLEEP |-> st.wake_flag;
  endproperty
  a_wake_flag: assert property (p_wake_flag) else $error("wake flag not set");

  property p_typ_hold;
    @(posedge CLK_IN) disable iff (!NRST_IN || !CE_IN)
    st.fsm != sss_pkg::ST_IDLE |=> $stable(st.typ);
  endproperty
  a_typ_hold: assert property (p_typ_hold) else $error("sleep type changed");

  property p_go_zero;
    @(posedge CLK_IN) disable iff (!NRST_IN || !CE_IN)
    REG_BUS_IN.rd && REG_BUS_IN.addr == sss_pkg::A_CTRL |=> !RDATA_OUT[sss_pkg::CTRL_GO_BIT];
  endproperty
  a_go_zero: assert property (p_go_zero) else $error("go bit read as one");

  property p_no_wake;
    @(posedge CLK_IN) disable iff (!NRST_IN || !CE_IN)
    st.fsm == sss_pkg::ST_SLEEP && !wake |=> st.fsm == sss_pkg::ST_SLEEP;
  endproperty
  a_no_wake: assert property (p_no_wake) else $error("left sleep without wake");

  c_s1_cycle: cover property (@(posedge CLK_IN) st.fsm == sss_pkg::ST_EXIT &&
                              st.act_typ == sss_pkg::TYP_S1 ##[1:EXIT_MAX] PROC_HALT_CLK_N_OUT);
  c_s3_exit: cover property (@(posedge CLK_IN) $fell(st.dev_rst));
  c_fw: cover property (@(posedge CLK_IN) FW_REQ_OUT);
endmodule // sss_sequencer

// ---- inc/sss_pkg.sv ----
// What this block does
// - Shallow sleep code plus go asserts halt-clock
// - Stop-grant variant: enabled wake releases halt-clock
// - Clock-stop variant: halt, clock, refresh, PLL standby
// - Wake reverses entry, clocks restart no later than halt-clock release
// - Shallow sleep keeps processor, memory, chipset context
// - Second state: clocks stop, refresh, processor off
// - Second state wake resets processor to boot
// - Third state: refresh, isolate memory, remove power
// - Third state wake repowers and resets devices
// - Deepest state powers off all devices
// - Firmware command port hibernate value goes to firmware
// - Sleep type field is three bits wide
// - Go bit and type arrive in one write
// - Wake flag set while platform sleeps
// - Sleep type field held across sleeping session
package sss_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_WAKE_EN = 8'h08;
  localparam logic [7:0] A_INT_STS = 8'h0C;
  localparam logic [7:0] A_INT_EN = 8'h10;
  localparam logic [7:0] A_INT_CLR = 8'h14;
  localparam logic [7:0] A_FW_CMD = 8'h18;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_TYP_LSB = 0;
  localparam int CTRL_GO_BIT = 3;
  localparam int CTRL_CS_BIT = 4;
  localparam int STAT_WAKE_BIT = 0;
  localparam int STAT_FSM_LSB = 4;
  localparam int STAT_STEP_LSB = 8;
  localparam int STAT_CPURST_BIT = 11;
  localparam int STAT_DEVRST_BIT = 12;
  localparam int STAT_SRC_LSB = 16;
  localparam int INT_SLEEP = 0;
  localparam int INT_WAKE = 1;
  localparam int INT_FW = 2;
  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] TYP_S1 = 3'h1;
  localparam logic [2:0] TYP_S2 = 3'h2;
  localparam logic [2:0] TYP_S3 = 3'h3;
  localparam logic [2:0] TYP_S4 = 3'h4;
  localparam logic [7:0] FW_HIB_REQ = 8'h40;
  localparam logic [7:0] RST_WAKE_EN = 8'h00;
  localparam logic [2:0] RST_INT_EN = 3'h0;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int STEP_NS = 100;
  localparam int STEP_CYC = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ENTER = 4'b0010,
    ST_SLEEP = 4'b0100,
    ST_EXIT = 4'b1000
  } sss_state_e;
  typedef struct packed {
    logic pwr_off;
    logic mem_iso;
    logic cpu_off;
    logic pll_stby;
    logic self_ref;
    logic clk_stop;
    logic halt;
  } sss_ctl_s;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } sss_bus_s;
endpackage

// ---- rtl/sss_step_timer.sv ----
`timescale 1ns/1ps
module sss_step_timer (
  input logic clk_in,
  input logic nrst_in,
  input logic ce_in,
  input logic start_in,
  output logic done_out
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [7:0] cnt;
  } sss_tmr_s;
  sss_tmr_s st;
  sss_tmr_s next_st;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (start_in) begin
      next_st.busy = 1'b1;
      next_st.cnt = 8'(sss_pkg::STEP_CYC - 1);
    end else if (st.busy) begin
      if (st.cnt == 8'h00) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.cnt = st.cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st <= '0;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign done_out = st.done;
endmodule // sss_step_timer

// ---- rtl/sss_wake_qual.sv ----
`timescale 1ns/1ps
module sss_wake_qual (
  input logic clk_in,
  input logic nrst_in,
  input logic ce_in,
  input logic [7:0] src_in,
  input logic [7:0] en_in,
  output logic [7:0] hit_out,
  output logic wake_out
);
  typedef struct packed {
    logic wake;
    logic [7:0] hit;
  } sss_wq_s;
  sss_wq_s st;
  sss_wq_s next_st;
  logic [7:0] hit_c;

  // Disabled sources are masked off bit by bit
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_src
      assign hit_c[i] = src_in[i] & en_in[i];
    end
  endgenerate

  always_comb begin
    next_st = st;
    next_st.hit = hit_c;
    next_st.wake = |hit_c;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st <= '0;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign hit_out = st.hit;
  assign wake_out = st.wake;
endmodule // sss_wake_qual

// ---- sim/sss_far_side.sv ----
`timescale 1ns/1ps
module sss_far_side (
  input logic clk_in,
  input logic nrst_in,
  input logic halt_n_in,
  input sss_pkg::sss_ctl_s ctl_in,
  output logic ctx_err_out
);
  // ----
  // Processor, clock and memory context
  // ----
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctx_err_out <= 1'b0;
    end else if ((ctl_in.clk_stop || ctl_in.cpu_off) && halt_n_in) begin
      ctx_err_out <= 1'b1;
    end else if (ctl_in.mem_iso && !ctl_in.self_ref) begin
      ctx_err_out <= 1'b1;
    end
  end
endmodule // sss_far_side

// ---- sim/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  sss_pkg::sss_bus_s bus = '0;
  logic [7:0] wsrc = 8'h00;
  logic [31:0] rdata;
  logic halt_n, cpu_rst, dev_rst, fw_req, irq, ctx_err;
  sss_pkg::sss_ctl_s ctl;
  logic [6:0] last_ctl = '0;
  logic [7:0] msk;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  int fw_cnt = 0;
  int base, e;
  bit cpu_seen, dev_seen;
  int tr[$];
  int tt[$];
  int tbl[5][4] = '{'{1, 0, 0, 0}, '{1, 3, 7, 15}, '{11, 15, 31, 0}, '{4, 36, 127, 0},
                    '{91, 0, 0, 0}};
  int len[5] = '{1, 4, 3, 3, 1};
  int typ[5] = '{1, 1, 2, 3, 4};
  logic [7:0] zr[7] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};

  always #2.5 clk = ~clk;

  sss_sequencer dut (.CLK_IN(clk), .NRST_IN(nrst), .CE_IN(ce), .REG_BUS_IN(bus),
    .WAKE_SRC_IN(wsrc), .RDATA_OUT(rdata), .PROC_HALT_CLK_N_OUT(halt_n),
    .SEQ_CTL_OUT(ctl), .CPU_RESET_OUT(cpu_rst), .DEV_RESET_OUT(dev_rst),
    .FW_REQ_OUT(fw_req), .IRQ_OUT(irq));
  sss_far_side far (.clk_in(clk), .nrst_in(nrst), .halt_n_in(halt_n), .ctl_in(ctl),
    .ctx_err_out(ctx_err));

  task chk(input bit ok, input string msg);
    checked++;
    if (!ok) begin
      num_errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task results;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----
  // Register bus master
  // ----
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input string s);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge clk);
    bus <= '0;
    #1;
    chk((rdata & m) === x, s);
  endtask

  task wait_irq(input string s);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk(irq === 1'b1, s);
  endtask

  // ----
  // Step trace of the far-side controls
  // ----
  always @(posedge clk) begin
    cyc++;
    if (nrst) begin
      if (ctl !== last_ctl) begin
        tr.push_back(int'(ctl));
        tt.push_back(cyc);
        last_ctl = ctl;
      end
      cpu_seen |= cpu_rst;
      dev_seen |= dev_rst;
      fw_cnt += int'(fw_req);
      chk(halt_n === !ctl.halt, "halt-clock level");
    end
  end

  initial begin
    #200000;
    num_errors++;
    $display("BAD %0t run limit reached", $time);
    results();
  end

  initial begin
    void'($urandom(20));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd(sss_pkg::A_STATUS, 32'h0000_18F1, 32'h0000_0010, "status reset");
    for (int i = 0; i < 7; i++) rd(zr[i], 32'hFFFF_FFFF, 32'h0000_0000, "reset value");
    chk(halt_n === 1'b1 && irq === 1'b0, "reset outputs");
    wr(sss_pkg::A_CTRL, 32'h0000_000D);
    repeat (30) @(posedge clk);
    rd(sss_pkg::A_STATUS, 32'h0000_00F0, 32'h0000_0010, "unsupported code");
    chk(tr.size() == 0, "no step on unsupported code");
    $display("test reset and codes done");
    wr(sss_pkg::A_INT_EN, 32'h0000_0003);
    for (int m = 0; m < 5; m++) begin
      msk = 8'h01 << ($urandom % 8);
      tr.delete();
      tt.delete();
      cpu_seen = 0;
      dev_seen = 0;
      wr(sss_pkg::A_WAKE_EN, {24'h00_0000, msk});
      // Caches count as flushed at this point
      wr(sss_pkg::A_CTRL, 32'(typ[m] + 8 + ((m == 1) ? 16 : 0)));
      wait_irq("sleep reached");
      wsrc <= ~msk;
      wr(sss_pkg::A_CTRL, 32'h0000_000A);
      rd(sss_pkg::A_CTRL, 32'h0000_000F, 32'(typ[m]), "type held, go reads 0");
      rd(sss_pkg::A_STATUS, 32'h00FF_18F1, 32'h0000_0041, "asleep status");
      wr(sss_pkg::A_INT_CLR, 32'h0000_0007);
      repeat (40) @(posedge clk);
      chk(irq === 1'b0 && tr.size() == len[m], "disabled source ignored");
      wsrc <= 8'hFF;
      wait_irq("wake done");
      wsrc <= 8'h00;
      // Let the trace take the final idle controls before it is read
      @(posedge clk);
      chk(cpu_seen == (m >= 2) && dev_seen == (m >= 3), "exit resets");
      chk(tr.size() == 2 * len[m], "step count");
      for (int i = 0; i < tr.size() && i < 2 * len[m]; i++) begin
        e = (i < len[m]) ? tbl[m][i] : (i == 2 * len[m] - 1) ? 0 : tbl[m][2 * len[m] - 2 - i];
        chk(tr[i] == e, "step value");
        if (i > 0 && i != len[m]) begin
          chk(tt[i] - tt[i - 1] == sss_pkg::STEP_CYC + 1, "step spacing");
        end
      end
      rd(sss_pkg::A_STATUS, 32'h0000_18F1, 32'h0000_0011, "idle, wake flag kept");
      wr(sss_pkg::A_STATUS, 32'h0000_0001);
      wr(sss_pkg::A_INT_CLR, 32'h0000_0007);
      $display("test sleep type %0d done", typ[m]);
    end
    base = fw_cnt;
    wr(sss_pkg::A_INT_EN, 32'h0000_0004);
    wr(sss_pkg::A_FW_CMD, 32'h0000_0041);
    wr(sss_pkg::A_FW_CMD, {24'h00_0000, sss_pkg::FW_HIB_REQ});
    repeat (3) @(posedge clk);
    chk(fw_cnt - base == 1 && irq === 1'b1, "one firmware request");
    wr(sss_pkg::A_INT_EN, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk(irq === 1'b0, "interrupt masked");
    rd(sss_pkg::A_INT_STS, 32'hFFFF_FFFF, 32'h0000_0004, "firmware status sticky");
    wr(sss_pkg::A_INT_CLR, 32'h0000_0004);
    wr(sss_pkg::A_INT_EN, 32'h0000_0004);
    repeat (2) @(posedge clk);
    chk(irq === 1'b0, "interrupt cleared");
    // A request made while the clock enable is low must not be taken
    ce <= 1'b0;
    wr(sss_pkg::A_FW_CMD, {24'h00_0000, sss_pkg::FW_HIB_REQ});
    repeat (2) @(posedge clk);
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    chk(fw_cnt - base == 1 && irq === 1'b0, "frozen while disabled");
    chk(ctx_err === 1'b0, "far side context");
    $display("test firmware and interrupt done");
    results();
  end
endmodule // tb
